// *** src/i2c_master_stop_and_arbitration.sv ***
// Two-wire master condition engine: Start, Repeated Start, Stop, collisions
//
// Overview of operation
// - Buffer write during Acknowledge sets write collision flag, write is dropped.
// - After a byte SCL stays low; stop request makes master drive SDA low.
// - SDA low in Stop reloads baud count; timeout releases SCL, later SDA.
// - SDA high with SCL high sets stop-seen; one period later interrupt, request clears.
// - Buffer write during Stop sets write collision flag, write is dropped.
// - In sleep, address match or completed byte wakes processor if interrupt enabled.
// - Reset disables the port and aborts any transfer.
// - Start-seen and stop-seen flags clear on reset or port disable.
// - Busy bus with interrupt enabled, port idle: detected Stop raises port interrupt.
// - Driven one sampled zero sets collision flag and returns port to idle.
// - Transmit collision halts, clears buffer full, releases lines, accepts writes.
// - Condition collision aborts it, releases lines, clears its request bits.
// - After collision, keep monitoring; a Stop on a busy bus flags interrupt if interrupt enabled.
// - After collision, buffer write restarts transmission at first data bit.
// - SDA or SCL low at Start begin aborts Start with collision.
// - Start loads baud count on SDA high; SCL low with SDA high collides.
// - SDA low during first Start count resets count and drives SDA early.
// - After SDA low, recount ignoring SCL, then drive SCL low.
// - Repeated Start counts, releases SCL; SCL high with SDA low collides.
// - In second count SDA fall is fine; SCL fall before SDA drive collides.
// - Both high at count end: drive SDA low, recount, then drive SCL low.
// - Baud generator reloads from reload value; bus clock is ref_clk_i over 2(n+1).
`timescale 1ns/1ps
module i2c_master_stop_and_arbitration (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic port_enable_i,
   input wire logic [i2c_stop_arb_pkg::RELOAD_W-1:0] baud_reload_value_i,
   input wire logic start_request_i,
   input wire logic restart_request_i,
   input wire logic stop_request_i,
   input wire logic ack_request_i,
   input wire logic ack_data_i,
   input wire logic buffer_write_i,
   input wire logic [7:0] buffer_wdata_i,
   input wire logic write_collision_clear_i,
   input wire logic collision_clear_i,
   input wire logic port_interrupt_clear_i,
   input wire logic port_interrupt_enable_i,
   input wire logic sleep_i,
   input wire logic slave_event_i,
   input wire logic sda_i,
   input wire logic scl_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic scl_o,
   output logic scl_oe_o,
   output logic start_request_o,
   output logic restart_request_o,
   output logic stop_request_o,
   output logic ack_request_o,
   output logic write_collision_flag_o,
   output logic collision_interrupt_flag_o,
   output logic port_interrupt_flag_o,
   output logic buffer_full_flag_o,
   output logic start_seen_o,
   output logic stop_seen_o,
   output logic bus_free_o,
   output logic wake_o,
   output logic [7:0] transfer_buffer_o
);
   import i2c_stop_arb_pkg::*;

   // Pins come from outside, two flops before use
   logic sda_m_reg, sda_s_reg, scl_m_reg, scl_s_reg, sda_d_reg, scl_d_reg;
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sda_m_reg <= 1'b1;
         sda_s_reg <= 1'b1;
         scl_m_reg <= 1'b1;
         scl_s_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         scl_d_reg <= 1'b1;
      end else begin
         sda_m_reg <= sda_i;
         sda_s_reg <= sda_m_reg;
         scl_m_reg <= scl_i;
         scl_s_reg <= scl_m_reg;
         sda_d_reg <= sda_s_reg;
         scl_d_reg <= scl_s_reg;
      end
   end

   wire sda = sda_s_reg;
   wire scl = scl_s_reg;
   wire bus_start = scl && scl_d_reg && sda_d_reg && !sda;
   wire bus_stop = scl && scl_d_reg && !sda_d_reg && sda;

   cond_state_t state_reg, state_next;
   logic [7:0] baud_reg, baud_next;
   logic sda_drv_reg, sda_drv_next, scl_drv_reg, scl_drv_next;
   logic sreq_reg, sreq_next, rreq_reg, rreq_next, preq_reg, preq_next;
   logic areq_reg, areq_next, write_collision_flag_reg, write_collision_flag_next, bcl_reg, bcl_next;
   logic pif_reg, pif_next, bf_reg, bf_next, ss_reg, ss_next, ps_reg, ps_next;
   logic wake_reg, wake_next, busy_reg, busy_next;
   logic free_reg, free_next;
   logic [7:0] buf_reg, buf_next, shift_reg, shift_next;
   logic [3:0] bit_reg, bit_next;
   logic ack_phase_reg, ack_phase_next;

   function automatic logic timeout(input logic [7:0] cnt);
      return cnt == 8'h00;
   endfunction

   always_comb begin
      state_next = state_reg;
      baud_next = (baud_reg != 8'h00) ? baud_reg - 8'h01 : 8'h00;
      sda_drv_next = sda_drv_reg;
      scl_drv_next = scl_drv_reg;
      sreq_next = sreq_reg | start_request_i;
      rreq_next = rreq_reg | restart_request_i;
      preq_next = preq_reg | stop_request_i;
      areq_next = areq_reg | ack_request_i;
      write_collision_flag_next = write_collision_flag_reg & ~write_collision_clear_i;
      bcl_next = bcl_reg & ~collision_clear_i;
      pif_next = pif_reg & ~port_interrupt_clear_i;
      bf_next = bf_reg;
      buf_next = buf_reg;
      shift_next = shift_reg;
      bit_next = bit_reg;
      ack_phase_next = ack_phase_reg;
      ss_next = ss_reg;
      ps_next = ps_reg;
      busy_next = busy_reg;
      wake_next = sleep_i & slave_event_i & port_interrupt_enable_i;
      if (bus_start) begin
         ss_next = 1'b1;
         ps_next = 1'b0;
         busy_next = 1'b1;
      end
      if (bus_stop) begin
         ps_next = 1'b1;
         ss_next = 1'b0;
         busy_next = 1'b0;
      end
      // detected Stop on busy bus while idle, interrupt enabled
      if (bus_stop && state_reg == ST_IDLE && port_interrupt_enable_i && busy_reg) begin
         pif_next = 1'b1;
      end
      // writes refused during Ack or Stop
      if (buffer_write_i) begin
         if (areq_reg || state_reg inside {ST_P1, ST_P2, ST_P3, ST_P4}
             || state_reg == ST_XMIT) begin
            write_collision_flag_next = 1'b1;
         end else if (state_reg == ST_IDLE) begin
            buf_next = buffer_wdata_i;
            shift_next = buffer_wdata_i;
            bf_next = 1'b1;
            bit_next = 4'h0;
            state_next = ST_XMIT;
            baud_next = baud_reload_value_i;
            scl_drv_next = 1'b1;
         end
      end
      case (state_reg)
         ST_IDLE: begin
            if (sreq_reg) begin
               sda_drv_next = 1'b0;
               scl_drv_next = 1'b0;
               state_next = ST_SCHK;
            end else if (rreq_reg) begin
               sda_drv_next = 1'b0;
               baud_next = baud_reload_value_i;
               state_next = ST_R1;
            end else if (preq_reg) begin
               // drive SDA low with SCL held
               sda_drv_next = 1'b1;
               scl_drv_next = 1'b1;
               state_next = ST_P1;
            end else if (areq_reg) begin
               sda_drv_next = !ack_data_i;
               scl_drv_next = 1'b1;
               baud_next = baud_reload_value_i;
               ack_phase_next = 1'b0;
               state_next = ST_P4;
            end
         end
         ST_SCHK: begin
            // lines must be high at Start
            if (!sda || !scl) begin
               bcl_next = 1'b1;
               sreq_next = 1'b0;
               state_next = ST_IDLE;
            end else begin
               baud_next = baud_reload_value_i;
               state_next = ST_S1;
            end
         end
         ST_S1: begin
            if (!sda || timeout(baud_reg)) begin
               sda_drv_next = 1'b1;
               baud_next = baud_reload_value_i;
               state_next = ST_S2;
            end else if (!scl) begin
               bcl_next = 1'b1;
               sreq_next = 1'b0;
               state_next = ST_IDLE;
            end
         end
         ST_S2: begin
            // SCL ignored, drive SCL at end
            if (timeout(baud_reg)) begin
               scl_drv_next = 1'b1;
               sreq_next = 1'b0;
               pif_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_R1: begin
            if (timeout(baud_reg)) begin
               scl_drv_next = 1'b0;
               state_next = ST_R2;
            end
         end
         ST_R2: begin
            if (scl) begin
               if (!sda) begin
                  bcl_next = 1'b1;
                  rreq_next = 1'b0;
                  sda_drv_next = 1'b0;
                  state_next = ST_IDLE;
               end else begin
                  baud_next = baud_reload_value_i;
                  state_next = ST_R3;
               end
            end
         end
         ST_R3: begin
            // SCL fall before SDA is a collision
            if (!scl && !sda_drv_reg) begin
               bcl_next = 1'b1;
               rreq_next = 1'b0;
               state_next = ST_IDLE;
            end else if (timeout(baud_reg)) begin
               if (!sda_drv_reg) begin
                  sda_drv_next = 1'b1;
                  baud_next = baud_reload_value_i;
               end else begin
                  scl_drv_next = 1'b1;
                  rreq_next = 1'b0;
                  pif_next = 1'b1;
                  state_next = ST_IDLE;
               end
            end
         end
         ST_P1: begin
            // SDA low seen, reload and count
            if (!sda) begin
               baud_next = baud_reload_value_i;
               state_next = ST_P2;
            end
         end
         ST_P2: begin
            if (timeout(baud_reg)) begin
               if (scl_drv_reg) begin
                  scl_drv_next = 1'b0;
                  baud_next = baud_reload_value_i;
               end else begin
                  sda_drv_next = 1'b0;
                  state_next = ST_P3;
               end
            end
         end
         ST_P3: begin
            // stop-seen then interrupt one period later
            if (sda && scl && !ps_reg) begin
               ps_next = 1'b1;
               baud_next = baud_reload_value_i;
            end else if (ps_reg && timeout(baud_reg)) begin
               preq_next = 1'b0;
               pif_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_P4: begin
            // Acknowledge: low period, release SCL, high period, pull low
            if (sda_drv_reg == 1'b0 && scl && !sda && !ack_phase_reg) begin
               bcl_next = 1'b1;
               areq_next = 1'b0;
               scl_drv_next = 1'b0;
               state_next = ST_IDLE;
            end else if (timeout(baud_reg)) begin
               if (scl_drv_reg) begin
                  scl_drv_next = 1'b0;
                  baud_next = baud_reload_value_i;
               end else if (scl) begin
                  scl_drv_next = 1'b1;
                  sda_drv_next = 1'b0;
                  areq_next = 1'b0;
                  pif_next = 1'b1;
                  state_next = ST_IDLE;
               end
            end
         end
         ST_XMIT: begin
            if (timeout(baud_reg)) begin
               baud_next = baud_reload_value_i;
               if (scl_drv_reg) begin
                  sda_drv_next = (bit_reg < BIT_LAST) ? !shift_reg[7] : 1'b0;
                  scl_drv_next = 1'b0;
               end else if (scl) begin
                  if (bit_reg < BIT_LAST && !sda_drv_reg && !sda) begin
                     bcl_next = 1'b1;
                     bf_next = 1'b0;
                     sda_drv_next = 1'b0;
                     state_next = ST_IDLE;
                  end else if (bit_reg == BIT_LAST) begin
                     scl_drv_next = 1'b1;
                     sda_drv_next = 1'b0;
                     pif_next = 1'b1;
                     state_next = ST_IDLE;
                  end else begin
                     scl_drv_next = 1'b1;
                     shift_next = {shift_reg[6:0], 1'b0};
                     bit_next = bit_reg + 4'h1;
                     if (bit_reg + 4'h1 == BIT_LAST) begin
                        bf_next = 1'b0;
                     end
                  end
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      if (bcl_next && !bcl_reg && state_next == ST_IDLE) begin
         sda_drv_next = 1'b0;
         scl_drv_next = 1'b0;
      end
      // disabled port aborts and clears seen flags
      if (!port_enable_i) begin
         state_next = ST_IDLE;
         sda_drv_next = 1'b0;
         scl_drv_next = 1'b0;
         sreq_next = 1'b0;
         rreq_next = 1'b0;
         preq_next = 1'b0;
         areq_next = 1'b0;
         ss_next = 1'b0;
         ps_next = 1'b0;
         busy_next = 1'b0;
      end
      // registered so the output comes from a flop
      free_next = ps_next | ~(ss_next | ps_next);
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg <= ST_IDLE;
         baud_reg <= 8'h00;
         sda_drv_reg <= 1'b0;
         scl_drv_reg <= 1'b0;
         sreq_reg <= 1'b0;
         rreq_reg <= 1'b0;
         preq_reg <= 1'b0;
         areq_reg <= 1'b0;
         write_collision_flag_reg <= 1'b0;
         bcl_reg <= 1'b0;
         pif_reg <= 1'b0;
         bf_reg <= 1'b0;
         ss_reg <= 1'b0;
         ps_reg <= 1'b0;
         busy_reg <= 1'b0;
         wake_reg <= 1'b0;
         free_reg <= 1'b1;
         buf_reg <= BUFFER_RESET;
         shift_reg <= BUFFER_RESET;
         bit_reg <= 4'h0;
         ack_phase_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         baud_reg <= baud_next;
         sda_drv_reg <= sda_drv_next;
         scl_drv_reg <= scl_drv_next;
         sreq_reg <= sreq_next;
         rreq_reg <= rreq_next;
         preq_reg <= preq_next;
         areq_reg <= areq_next;
         write_collision_flag_reg <= write_collision_flag_next;
         bcl_reg <= bcl_next;
         pif_reg <= pif_next;
         bf_reg <= bf_next;
         ss_reg <= ss_next;
         ps_reg <= ps_next;
         busy_reg <= busy_next;
         wake_reg <= wake_next;
         free_reg <= free_next;
         buf_reg <= buf_next;
         shift_reg <= shift_next;
         bit_reg <= bit_next;
         ack_phase_reg <= ack_phase_next;
      end
   end

   // Open drain: pin output always low, enable pulls
   assign sda_o = 1'b0;
   assign scl_o = 1'b0;
   assign sda_oe_o = sda_drv_reg;
   assign scl_oe_o = scl_drv_reg;
   assign start_request_o = sreq_reg;
   assign restart_request_o = rreq_reg;
   assign stop_request_o = preq_reg;
   assign ack_request_o = areq_reg;
   assign write_collision_flag_o = write_collision_flag_reg;
   assign collision_interrupt_flag_o = bcl_reg;
   assign port_interrupt_flag_o = pif_reg;
   assign buffer_full_flag_o = bf_reg;
   assign start_seen_o = ss_reg;
   assign stop_seen_o = ps_reg;
   // software may take bus when this is high
   assign bus_free_o = free_reg;
   assign wake_o = wake_reg;
   assign transfer_buffer_o = buf_reg;
endmodule

// *** common/i2c_stop_arb_pkg.sv ***
// Constants and state codes for the two-wire master condition engine
package i2c_stop_arb_pkg;
   localparam int RELOAD_W = 8;
   localparam logic [7:0] RELOAD_RESET = 8'h4F;
   localparam logic [7:0] RELOAD_MIN = 8'h03;
   localparam int BIT_COUNT = 8;
   localparam logic [3:0] BIT_LAST = 4'h8;
   localparam logic [7:0] BUFFER_RESET = 8'h00;

   typedef enum logic [11:0] {
      ST_IDLE  = 12'h001,
      ST_SCHK  = 12'h002,
      ST_S1    = 12'h004,
      ST_S2    = 12'h008,
      ST_R1    = 12'h010,
      ST_R2    = 12'h020,
      ST_R3    = 12'h040,
      ST_P1    = 12'h080,
      ST_P2    = 12'h100,
      ST_P3    = 12'h200,
      ST_P4    = 12'h400,
      ST_XMIT  = 12'h800
   } cond_state_t;
endpackage

// *** test/i2c_stop_arb_properties.sv ***
// Port-level checks for the two-wire master condition engine
`timescale 1ns/1ps
module i2c_stop_arb_properties (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic port_enable_i,
   input wire logic buffer_write_i,
   input wire logic write_collision_clear_i,
   input wire logic collision_clear_i,
   input wire logic sleep_i,
   input wire logic slave_event_i,
   input wire logic port_interrupt_enable_i,
   input wire logic sda_oe_o,
   input wire logic scl_oe_o,
   input wire logic start_request_o,
   input wire logic restart_request_o,
   input wire logic stop_request_o,
   input wire logic ack_request_o,
   input wire logic write_collision_flag_o,
   input wire logic collision_interrupt_flag_o,
   input wire logic port_interrupt_flag_o,
   input wire logic start_seen_o,
   input wire logic stop_seen_o,
   input wire logic bus_free_o,
   input wire logic wake_o,
   input wire logic [7:0] transfer_buffer_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   AST_WRITE_COLLISION_FLAG_HOLD:
   assert property (write_collision_flag_o && !write_collision_clear_i |=> write_collision_flag_o)
      else $error("write collision flag dropped");
   AST_BCL_HOLD:
   assert property (collision_interrupt_flag_o && !collision_clear_i
      |=> collision_interrupt_flag_o) else $error("collision flag dropped");
   AST_WRITE_REFUSED:
   assert property (buffer_write_i && (stop_request_o || ack_request_o)
      |=> $stable(transfer_buffer_o) && write_collision_flag_o) else $error("write not refused");
   AST_COLLISION_RELEASE:
   assert property ($rose(collision_interrupt_flag_o) |-> ##[0:2] (!sda_oe_o && !scl_oe_o
      && !start_request_o && !restart_request_o && !stop_request_o && !ack_request_o))
      else $error("collision left lines or requests held");
   AST_DISABLE_CLEARS:
   assert property (!port_enable_i ##1 !port_enable_i |-> !start_seen_o && !stop_seen_o
      && !sda_oe_o && !scl_oe_o) else $error("disabled port not quiet");
   AST_BUS_FREE:
   assert property (bus_free_o == (stop_seen_o || !start_seen_o)) else $error("bus free wrong");
   AST_STOP_DRIVES_SDA:
   assert property ($rose(stop_request_o) |-> ##[1:2] sda_oe_o) else $error("stop left SDA");
   AST_STOP_SDA_AFTER_SCL:
   assert property ($fell(scl_oe_o) && stop_request_o |-> sda_oe_o [*4])
      else $error("SDA released early in stop");
   AST_STOP_FINISH:
   assert property ($rose(stop_seen_o) && stop_request_o
      |-> ##[4:300] ($fell(stop_request_o) && port_interrupt_flag_o))
      else $error("stop not finished");
   AST_START_ORDER:
   assert property ($rose(scl_oe_o) && $past(start_request_o) |-> sda_oe_o)
      else $error("SCL before SDA");
   AST_WAKE:
   assert property (sleep_i && port_interrupt_enable_i && slave_event_i |-> ##[1:2] wake_o)
      else $error("no wake");
endmodule
bind i2c_master_stop_and_arbitration i2c_stop_arb_properties u_i2c_stop_arb_properties (
   .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .port_enable_i(port_enable_i),
   .buffer_write_i(buffer_write_i), .write_collision_clear_i(write_collision_clear_i),
   .collision_clear_i(collision_clear_i), .sleep_i(sleep_i), .slave_event_i(slave_event_i),
   .port_interrupt_enable_i(port_interrupt_enable_i), .sda_oe_o(sda_oe_o), .scl_oe_o(scl_oe_o),
   .start_request_o(start_request_o), .restart_request_o(restart_request_o),
   .stop_request_o(stop_request_o), .ack_request_o(ack_request_o),
   .write_collision_flag_o(write_collision_flag_o),
   .collision_interrupt_flag_o(collision_interrupt_flag_o),
   .port_interrupt_flag_o(port_interrupt_flag_o), .start_seen_o(start_seen_o),
   .stop_seen_o(stop_seen_o), .bus_free_o(bus_free_o), .wake_o(wake_o),
   .transfer_buffer_o(transfer_buffer_o));

// *** test/i2c_bus_partner.sv ***
// Pulled-up bus wires with a second master able to hold either line low
`timescale 1ns/1ps
module i2c_bus_partner (
   input wire logic sda_oe_i,
   input wire logic scl_oe_i,
   input wire logic sda_hold_i,
   input wire logic scl_hold_i,
   output logic sda_line_o,
   output logic scl_line_o
);
   // Wired-and; a released line floats to the pull-up level
   assign scl_line_o = !(scl_oe_i || scl_hold_i);
   assign sda_line_o = !(sda_oe_i || sda_hold_i);
endmodule

// *** test/tb_i2c_master_stop_and_arbitration.sv ***
// Self-checking bench for the two-wire master condition engine
`timescale 1ns/1ps
module tb_i2c_master_stop_and_arbitration;
   import i2c_stop_arb_pkg::*;
   typedef struct {int sel; logic [7:0] mask; logic [7:0] exp;} note_t;
   logic ref_clk_i = 1'b0, reset_n_i = 1'b0, p_en = 1'b0, pi_en = 1'b0, slp = 1'b0;
   logic st_rq = 1'b0, sp_rq = 1'b0, ak_rq = 1'b0, bw = 1'b0, sev = 1'b0, rs_rq = 1'b0;
   logic wc_clr = 1'b0, bc_clr = 1'b0, pi_clr = 1'b0, sda_hold = 1'b0, scl_hold = 1'b0;
   logic [7:0] wdata = 8'h00, d1;
   logic sda_line, scl_line, sda_oe, scl_oe, s_rq, r_rq, p_rq, a_rq;
   logic write_collision_flag, bcl, pif, bf, s_seen, p_seen, bfree, wake;
   logic [7:0] tbuf;
   logic [31:0] lfsr = 32'hCFDC;
   int bad_count = 0, samples_checked = 0;
   note_t note_q[$];
   note_t cur;

   i2c_master_stop_and_arbitration u_i2c_master_stop_and_arbitration (
      .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .port_enable_i(p_en),
      .baud_reload_value_i(RELOAD_MIN), .start_request_i(st_rq), .restart_request_i(rs_rq),
      .stop_request_i(sp_rq), .ack_request_i(ak_rq), .ack_data_i(1'b0),
      .buffer_write_i(bw), .buffer_wdata_i(wdata), .write_collision_clear_i(wc_clr),
      .collision_clear_i(bc_clr), .port_interrupt_clear_i(pi_clr),
      .port_interrupt_enable_i(pi_en), .sleep_i(slp), .slave_event_i(sev),
      .sda_i(sda_line), .scl_i(scl_line), .sda_o(), .sda_oe_o(sda_oe), .scl_o(),
      .scl_oe_o(scl_oe), .start_request_o(s_rq), .restart_request_o(r_rq),
      .stop_request_o(p_rq), .ack_request_o(a_rq), .write_collision_flag_o(write_collision_flag),
      .collision_interrupt_flag_o(bcl), .port_interrupt_flag_o(pif),
      .buffer_full_flag_o(bf), .start_seen_o(s_seen), .stop_seen_o(p_seen),
      .bus_free_o(bfree), .wake_o(wake), .transfer_buffer_o(tbuf));

   i2c_bus_partner u_i2c_bus_partner (.sda_oe_i(sda_oe), .scl_oe_i(scl_oe),
      .sda_hold_i(sda_hold), .scl_hold_i(scl_hold), .sda_line_o(sda_line),
      .scl_line_o(scl_line));

   initial begin
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   function automatic logic [7:0] pick(int sel);
      case (sel)
         0: return {write_collision_flag, bcl, pif, bf, s_seen, p_seen, bfree, wake};
         1: return {2'h0, sda_oe, scl_oe, s_rq, r_rq, p_rq, a_rq};
         default: return tbuf;
      endcase
   endfunction

   function automatic logic [31:0] lfsr_next(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check_val(logic [7:0] seen, logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic tick(int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic note(int sel, logic [7:0] mask, logic [7:0] exp);
      note_q.push_back('{sel, mask, exp});
   endtask

   // One-cycle strobe; the trailing edge keeps back-to-back calls apart
   task automatic pls(int k);
      {sev, pi_clr, bc_clr, wc_clr, bw, ak_rq, sp_rq, st_rq} = 8'h01 << k;
      tick(1);
      {sev, pi_clr, bc_clr, wc_clr, bw, ak_rq, sp_rq, st_rq} = 8'h00;
      tick(1);
   endtask

   task automatic wait_for(int sel, logic [7:0] mask, logic [7:0] val, int bound);
      int i;
      for (i = 0; i < bound; i++) begin
         if ((pick(sel) & mask) === val) break;
         tick(1);
      end
      if (i == bound) begin
         bad_count++;
         $display("mismatch at %0t: wait ran out", $time);
         tally_and_finish();
      end
   endtask

   task automatic rnd_write();
      lfsr = lfsr_next(lfsr);
      wdata = lfsr[7:0];
      pls(3);
   endtask

   // Outputs are settled at the falling edge; notes are taken oldest first
   always @(negedge ref_clk_i) begin
      while (note_q.size() > 0) begin
         cur = note_q.pop_front();
         check_val(pick(cur.sel) & cur.mask, cur.exp & cur.mask);
      end
   end

   initial begin
      tick(20);
      reset_n_i = 1'b1;
      p_en = 1'b1;
      pi_en = 1'b1;
      tick(4);
      note(0, 8'hFF, 8'h02);
      note(1, 8'hFF, 8'h00);
      note(2, 8'hFF, BUFFER_RESET);
      scl_hold = 1'b1;
      tick(4);
      pls(0);
      wait_for(0, 8'h40, 8'h40, 100);
      tick(2);
      note(1, 8'hFF, 8'h00);
      scl_hold = 1'b0;
      pls(5);
      note(0, 8'h40, 8'h00);
      tick(4);
      // bus idle, both seen flags clear
      pls(0);
      wait_for(1, 8'h08, 8'h00, 300);
      note(0, 8'h40, 8'h00);
      note(1, 8'h30, 8'h30);
      lfsr = lfsr_next(lfsr);
      d1 = lfsr[7:0];
      wdata = d1;
      pls(3);
      note(2, 8'hFF, d1);
      wait_for(0, 8'h10, 8'h00, 2000);
      wait_for(1, 8'h10, 8'h00, 300);
      wait_for(1, 8'h10, 8'h10, 300);
      pls(2);
      rnd_write();
      note(0, 8'h80, 8'h80);
      note(2, 8'hFF, d1);
      wait_for(1, 8'h01, 8'h00, 400);
      pls(4);
      note(0, 8'h80, 8'h00);
      pls(6);
      pls(1);
      tick(2);
      rnd_write();
      note(0, 8'h80, 8'h80);
      note(2, 8'hFF, d1);
      wait_for(1, 8'h02, 8'h00, 600);
      note(0, 8'h26, 8'h26);
      note(1, 8'h30, 8'h00);
      pls(4);
      p_en = 1'b0;
      tick(3);
      note(0, 8'h0C, 8'h00);
      note(1, 8'h3F, 8'h00);
      p_en = 1'b1;
      tick(6);
      pls(0);
      wait_for(1, 8'h08, 8'h00, 300);
      pls(6);
      wdata = 8'hFF;
      sda_hold = 1'b1;
      pls(3);
      wait_for(0, 8'h40, 8'h40, 600);
      tick(2);
      note(0, 8'h50, 8'h40);
      note(1, 8'h3F, 8'h00);
      tick(4);
      // A rival releasing SDA with SCL high is a bus stop
      sda_hold = 1'b0;
      wait_for(0, 8'h24, 8'h24, 50);
      note(0, 8'h24, 8'h24);
      pls(5);
      rnd_write();
      note(2, 8'hFF, wdata);
      note(0, 8'h10, 8'h10);
      wait_for(0, 8'h10, 8'h00, 2000);
      tick(100);
      // Repeated Start from a held clock, no rival
      rs_rq = 1'b1;
      tick(1);
      rs_rq = 1'b0;
      wait_for(1, 8'h04, 8'h00, 300);
      note(1, 8'h30, 8'h30);
      note(0, 8'h4C, 8'h08);
      tick(4);
      slp = 1'b1;
      sev = 1'b1;
      tick(1);
      note(0, 8'h01, 8'h01);
      sev = 1'b0;
      tick(1);
      note(0, 8'h01, 8'h00);
      pi_en = 1'b0;
      {sev} = 1'b1;
      tick(1);
      sev = 1'b0;
      repeat (3) begin
         note(0, 8'h01, 8'h00);
         tick(1);
      end
      tally_and_finish();
   end
endmodule
